/* hdl/serial_port_break_wake_sync_tx.sv */
// Serial port core: wake-on-edge, break transmission and clocked master transmit
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "sp_defs.svh"

module serial_port_break_wake_sync_tx
	import sp_pkg::*;
(
	input  wire logic       clock_i,         // 50 MHz system clock
	input  wire logic       srst_i,          // Synchronous reset, active high
	input  wire logic [2:0] addr_i,          // Register address
	input  wire logic [7:0] wdata_i,         // Register write data
	input  wire logic       wr_i,            // Write strobe
	input  wire logic       rd_i,            // Read strobe
	output logic      [7:0] rdata_o,         // Read data, cycle after strobe
	input  wire logic       rx_busy_i,       // Receiver engine is busy
	input  wire logic       rx_pin_i,        // receive_pin / shift_data_pin level
	output logic            rx_pin_o,        // shift_data_pin drive value
	output logic            rx_pin_oe_n_o,   // Low while driving the data pin
	output logic            tx_pin_o,        // transmit_pin or shift_clock_pin
	output logic            rx_enable_o,     // Receiver allowed to run
	output logic            rx_ready_flag_o, // receive_ready_flag
	output logic            tx_empty_flag_o  // transmit_buffer_empty_flag
);

	// ****************************************************************
	// Pin synchroniser and edge detect
	// ****************************************************************
	logic rx_meta_ff;
	logic rx_sync_ff;
	logic rx_prev_ff;
	logic rx_fall;
	logic rx_rise;

	// Two stages before any logic looks at the pin
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_meta_ff <= rx_pin_i;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end

	assign rx_fall = rx_prev_ff & ~rx_sync_ff;
	assign rx_rise = ~rx_prev_ff & rx_sync_ff;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0] rx_ctrl_ff,  nxt_rx_ctrl;
	tx_ctrl_s   tx_ctrl_ff,  nxt_tx_ctrl;
	logic [7:0] baud_ctrl_ff, nxt_baud_ctrl;
	logic [7:0] div_high_ff, nxt_div_high;
	logic [7:0] div_low_ff,  nxt_div_low;
	logic [7:0] tx_buf_ff,   nxt_tx_buf;
	logic       buf_full_ff, nxt_buf_full;
	logic       rx_flag_ff,  nxt_rx_flag;
	logic       tx_flag_ff,  nxt_tx_flag;
	logic       wake_seen_ff, nxt_wake_seen;
	logic [7:0] rdata_ff,    nxt_rdata;

	// Transmit sequencer state
	tx_state_e  state_ff,    nxt_state;
	logic [13:0] shreg_ff,   nxt_shreg;
	logic [3:0] bits_left_ff, nxt_bits_left;
	logic       is_break_ff, nxt_is_break;
	logic       phase_ff,    nxt_phase;
	logic [15:0] baud_cnt_ff, nxt_baud_cnt;
	logic       tx_pin_ff,   nxt_tx_pin;
	logic       dat_ff,      nxt_dat;
	logic       dat_oe_n_ff, nxt_dat_oe_n;
	logic       rx_en_ff,    nxt_rx_en;

	// Decoded controls
	logic       port_on;
	logic       sync_master;
	logic       wake_armed;
	logic       polarity;
	logic       load;
	logic       break_done;
	logic       baud_tick;
	logic [15:0] divisor;
	logic       wr_tx_buf;

	assign port_on     = rx_ctrl_ff[`SP_RX_PORT_ENABLE];
	assign sync_master = tx_ctrl_ff.clk_master & tx_ctrl_ff.clocked;
	assign wake_armed  = baud_ctrl_ff[`SP_BAUD_WAKE_EDGE];
	assign polarity    = baud_ctrl_ff[`SP_BAUD_POLARITY];
	assign wr_tx_buf   = wr_i & (addr_i == `SP_OFS_TX_BUFFER);
	// 8-bit divider unless the wide select is set
	assign divisor = baud_ctrl_ff[`SP_BAUD_WIDE_DIV] ? {div_high_ff, div_low_ff}
	                                                 : {8'h00, div_low_ff};
	assign baud_tick = (baud_cnt_ff == 16'h0000);

	// Load only when the last bit is out; the receiver blocks clocked sends
	assign load = state_ff[0] & buf_full_ff & tx_ctrl_ff.tx_enable & port_on
	              & ~(sync_master & rx_busy_i);
	assign break_done = state_ff[1] & baud_tick & is_break_ff
	                    & (bits_left_ff == 4'h1);

	// ****************************************************************
	// Register file and flags
	// ****************************************************************
	// Writes store, reads answer next cycle, hardware events set flags
	always_comb begin
		nxt_rx_ctrl   = rx_ctrl_ff;
		nxt_tx_ctrl   = tx_ctrl_ff;
		nxt_baud_ctrl = baud_ctrl_ff;
		nxt_div_high  = div_high_ff;
		nxt_div_low   = div_low_ff;
		nxt_tx_buf    = tx_buf_ff;
		nxt_buf_full  = buf_full_ff;
		nxt_rx_flag   = rx_flag_ff;
		nxt_tx_flag   = tx_flag_ff;
		nxt_wake_seen = wake_seen_ff;
		nxt_rdata     = 8'h00;

		// Hardware side of the register bits first, so a write overrides
		nxt_tx_ctrl.shift_empty = ~nxt_state[1];
		if (break_done) begin
			nxt_tx_ctrl.send_break = 1'b0;
		end
		if (wake_armed & ~wake_seen_ff & rx_fall) begin
			nxt_wake_seen = 1'b1;
		end
		if (wake_armed & wake_seen_ff & rx_rise) begin
			nxt_baud_ctrl[`SP_BAUD_WAKE_EDGE] = 1'b0;
			nxt_wake_seen = 1'b0;
		end
		if (~wake_armed) begin
			nxt_wake_seen = 1'b0;
		end

		// Register writes
		if (wr_i) begin
			unique case (addr_i)
				`SP_OFS_RX_STATUS_CTRL: nxt_rx_ctrl = wdata_i & `SP_MASK_RX_STATUS_CTRL;
				`SP_OFS_TX_BUFFER: begin
					nxt_tx_buf   = wdata_i;
					nxt_buf_full = 1'b1;
				end
				`SP_OFS_TX_STATUS_CTRL: begin
					nxt_tx_ctrl = (wdata_i & `SP_MASK_TX_STATUS_CTRL)
					              | {6'h00, nxt_tx_ctrl.shift_empty, 1'b0};
				end
				`SP_OFS_BAUD_CTRL:    nxt_baud_ctrl = wdata_i & `SP_MASK_BAUD_CTRL;
				`SP_OFS_BAUD_DIV_HIGH: nxt_div_high = wdata_i;
				`SP_OFS_BAUD_DIV_LOW:  nxt_div_low  = wdata_i;
				default: ;
			endcase
		end

		// Clears first, then sets, so an event in the clearing cycle survives
		if (rd_i & (addr_i == `SP_OFS_RX_DATA)) begin
			nxt_rx_flag = 1'b0;
		end
		if (wr_tx_buf) begin
			nxt_tx_flag = 1'b0;
		end
		if (wake_armed & ~wake_seen_ff & rx_fall) begin
			nxt_rx_flag = 1'b1;
		end
		if (load) begin
			nxt_buf_full = wr_tx_buf;
			nxt_tx_flag  = 1'b1;
		end

		// Read data; the receive register only yields dummy data here
		if (rd_i) begin
			unique case (addr_i)
				`SP_OFS_RX_STATUS_CTRL: nxt_rdata = rx_ctrl_ff;
				`SP_OFS_RX_DATA:        nxt_rdata = `SP_DUMMY_RX_DATA;
				`SP_OFS_TX_BUFFER:      nxt_rdata = tx_buf_ff;
				`SP_OFS_TX_STATUS_CTRL: nxt_rdata = tx_ctrl_ff;
				`SP_OFS_BAUD_CTRL: begin
					nxt_rdata = baud_ctrl_ff;
					nxt_rdata[`SP_BAUD_RX_IDLE] = ~rx_busy_i;
				end
				`SP_OFS_BAUD_DIV_HIGH:  nxt_rdata = div_high_ff;
				`SP_OFS_BAUD_DIV_LOW:   nxt_rdata = div_low_ff;
				`SP_OFS_FLAGS: begin
					nxt_rdata[`SP_FLAG_RX_READY] = rx_flag_ff;
					nxt_rdata[`SP_FLAG_TX_EMPTY] = tx_flag_ff;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rx_ctrl_ff   <= `SP_RST_RX_STATUS_CTRL;
			tx_ctrl_ff   <= `SP_RST_TX_STATUS_CTRL;
			baud_ctrl_ff <= `SP_RST_BAUD_CTRL;
			div_high_ff  <= `SP_RST_BAUD_DIV;
			div_low_ff   <= `SP_RST_BAUD_DIV;
			tx_buf_ff    <= 8'h00;
			buf_full_ff  <= 1'b0;
			rx_flag_ff   <= 1'b0;
			tx_flag_ff   <= 1'b1;
			wake_seen_ff <= 1'b0;
			rdata_ff     <= 8'h00;
		end else begin
			rx_ctrl_ff   <= nxt_rx_ctrl;
			tx_ctrl_ff   <= nxt_tx_ctrl;
			baud_ctrl_ff <= nxt_baud_ctrl;
			div_high_ff  <= nxt_div_high;
			div_low_ff   <= nxt_div_low;
			tx_buf_ff    <= nxt_tx_buf;
			buf_full_ff  <= nxt_buf_full;
			rx_flag_ff   <= nxt_rx_flag;
			tx_flag_ff   <= nxt_tx_flag;
			wake_seen_ff <= nxt_wake_seen;
			rdata_ff     <= nxt_rdata;
		end
	end

	// ****************************************************************
	// Transmit sequencer and pin drive
	// ****************************************************************
	// Async shifts one bit per tick; clocked mode spends two ticks a bit
	always_comb begin
		nxt_state     = state_ff;
		nxt_shreg     = shreg_ff;
		nxt_bits_left = bits_left_ff;
		nxt_is_break  = is_break_ff;
		nxt_phase     = phase_ff;
		nxt_baud_cnt  = baud_tick ? divisor : baud_cnt_ff - 16'h0001;
		nxt_tx_pin    = tx_pin_ff;
		nxt_dat       = dat_ff;
		nxt_dat_oe_n  = 1'b1;

		unique case (state_ff)
			TX_IDLE: begin
				if (load) begin
					nxt_state    = TX_SHIFT;
					nxt_phase    = 1'b0;
					nxt_baud_cnt = divisor;        // Full first bit after load
					nxt_is_break = tx_ctrl_ff.send_break & ~sync_master;
					if (sync_master) begin
						nxt_shreg     = {5'h1F, tx_ctrl_ff.ninth_data, tx_buf_ff};
						nxt_bits_left = tx_ctrl_ff.nine_bit ? `SP_BITS_SYNC9 : `SP_BITS_SYNC8;
					end else if (tx_ctrl_ff.send_break) begin
						// Buffer contents are thrown away for a break
						nxt_shreg     = {1'b1, {`SP_BREAK_ZEROS{1'b0}}, 1'b0};
						nxt_bits_left = `SP_BITS_BREAK;
					end else begin
						nxt_shreg     = {4'hF, tx_ctrl_ff.nine_bit ? tx_ctrl_ff.ninth_data : 1'b1,
						                 tx_buf_ff, 1'b0};
						nxt_bits_left = tx_ctrl_ff.nine_bit ? `SP_BITS_ASYNC9 : `SP_BITS_ASYNC8;
					end
				end
			end
			TX_SHIFT: begin
				if (baud_tick) begin
					if (sync_master & ~phase_ff) begin
						nxt_phase = 1'b1;          // Leave idle: receiver's edge comes next
					end else begin
						nxt_phase = 1'b0;
						nxt_shreg = {1'b1, shreg_ff[13:1]};
						nxt_bits_left = bits_left_ff - 4'h1;
						if (bits_left_ff == 4'h1) begin
							nxt_state = TX_IDLE;
						end
					end
				end
			end
			default: nxt_state = TX_IDLE;
		endcase

		// Pin roles follow mode; idle line stays at its mark or idle clock
		if (~port_on) begin
			nxt_tx_pin = 1'b1;
			nxt_dat    = 1'b1;
		end else if (sync_master) begin
			// Data moves at the idle-going edge, held across the other
			nxt_tx_pin = polarity ^ (nxt_state[1] & nxt_phase);
			nxt_dat    = nxt_shreg[0];
			nxt_dat_oe_n = ~nxt_state[1];
		end else begin
			nxt_tx_pin = nxt_state[1] ? nxt_shreg[0] : 1'b1;
			nxt_dat    = 1'b1;
		end

		// Receiver off while wake is armed or a clocked send runs
		nxt_rx_en = port_on & ~nxt_baud_ctrl[`SP_BAUD_WAKE_EDGE]
		            & ~(sync_master & nxt_state[1]);
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_ff     <= TX_IDLE;
			shreg_ff     <= 14'h3FFF;
			bits_left_ff <= 4'h0;
			is_break_ff  <= 1'b0;
			phase_ff     <= 1'b0;
			baud_cnt_ff  <= 16'h0000;
			tx_pin_ff    <= 1'b1;
			dat_ff       <= 1'b1;
			dat_oe_n_ff  <= 1'b1;
			rx_en_ff     <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			shreg_ff     <= nxt_shreg;
			bits_left_ff <= nxt_bits_left;
			is_break_ff  <= nxt_is_break;
			phase_ff     <= nxt_phase;
			baud_cnt_ff  <= nxt_baud_cnt;
			tx_pin_ff    <= nxt_tx_pin;
			dat_ff       <= nxt_dat;
			dat_oe_n_ff  <= nxt_dat_oe_n;
			rx_en_ff     <= nxt_rx_en;
		end
	end

	// ****************************************************************
	// Outputs, all straight from flip-flops
	// ****************************************************************
	assign rdata_o         = rdata_ff;
	assign rx_pin_o        = dat_ff;
	assign rx_pin_oe_n_o   = dat_oe_n_ff;
	assign tx_pin_o        = tx_pin_ff;
	assign rx_enable_o     = rx_en_ff;
	assign rx_ready_flag_o = rx_flag_ff;
	assign tx_empty_flag_o = tx_flag_ff;

endmodule

/* hdl/sp_defs.svh */
// Register offsets, field positions, reset values and counts for the serial port
`ifndef SP_DEFS_SVH
`define SP_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SP_OFS_RX_STATUS_CTRL  3'h0
`define SP_OFS_RX_DATA         3'h1
`define SP_OFS_TX_BUFFER       3'h2
`define SP_OFS_TX_STATUS_CTRL  3'h3
`define SP_OFS_BAUD_CTRL       3'h4
`define SP_OFS_BAUD_DIV_HIGH   3'h5
`define SP_OFS_BAUD_DIV_LOW    3'h6
`define SP_OFS_FLAGS           3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define SP_RX_PORT_ENABLE      7
`define SP_BAUD_POLARITY       4
`define SP_BAUD_WIDE_DIV       3
`define SP_BAUD_WAKE_EDGE      1
`define SP_BAUD_RX_IDLE        6
`define SP_FLAG_RX_READY       0
`define SP_FLAG_TX_EMPTY       1

// ****************************************************************
// Reset values, writable masks and dummy receive data
// ****************************************************************
`define SP_RST_RX_STATUS_CTRL  8'h00
`define SP_RST_TX_STATUS_CTRL  8'h02
`define SP_RST_BAUD_CTRL       8'h00
`define SP_RST_BAUD_DIV        8'h00
`define SP_MASK_RX_STATUS_CTRL 8'hF9
`define SP_MASK_TX_STATUS_CTRL 8'hFD
`define SP_MASK_BAUD_CTRL      8'h1B
`define SP_DUMMY_RX_DATA       8'h00

// ****************************************************************
// Frame lengths in bits
// ****************************************************************
`define SP_BREAK_ZEROS         12
`define SP_BITS_BREAK          4'hE
`define SP_BITS_ASYNC8         4'hA
`define SP_BITS_ASYNC9         4'hB
`define SP_BITS_SYNC8          4'h8
`define SP_BITS_SYNC9          4'h9

`endif

/* hdl/sp_pkg.sv */
// Types shared by the serial port break, wake and clocked transmit block
package sp_pkg;

	// Transmit status/control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic clk_master;     // Clock source master
		logic nine_bit;       // nine_bit_transmit_enable
		logic tx_enable;      // transmit_enable_bit
		logic clocked;        // Clocked (synchronous) mode
		logic send_break;     // send_break_bit
		logic high_speed;     // Stored only
		logic shift_empty;    // shift_empty_status, read only
		logic ninth_data;     // ninth_transmit_data_bit
	} tx_ctrl_s;

	// Transmit sequencer states, one-hot
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_e;

endpackage

/* testbench/sp_properties.sv */
// Port-level assertions for the serial port core
`timescale 1ns/1ps
`include "sp_defs.svh"

module sp_properties (
	input wire logic       clock_i,         // Clock
	input wire logic       srst_i,          // Reset
	input wire logic [2:0] addr_i,          // Address
	input wire logic [7:0] wdata_i,         // Unused
	input wire logic       wr_i,            // Write
	input wire logic       rd_i,            // Read
	input wire logic [7:0] rdata_o,         // Read data
	input wire logic       rx_busy_i,       // Rx busy
	input wire logic       rx_pin_i,        // Line
	input wire logic       rx_pin_o,        // Unused
	input wire logic       rx_pin_oe_n_o,   // Data enable
	input wire logic       tx_pin_o,        // Serial out
	input wire logic       rx_enable_o,     // Rx enable
	input wire logic       rx_ready_flag_o, // Rx flag
	input wire logic       tx_empty_flag_o  // Tx empty
);
	// ****************************************
	// Helpers
	// ****************************************
	logic [3:0] low_run_ff;
	logic [3:0] nxt_low_run;

	// Saturating count of low line samples
	always_comb begin
		nxt_low_run = rx_pin_i ? 4'h0 : low_run_ff + {3'h0, low_run_ff != 4'hF};
	end

	always_ff @(posedge clock_i) begin
		low_run_ff <= srst_i ? 4'h0 : nxt_low_run;
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	sequence buf_wr;
		wr_i && addr_i == `SP_OFS_TX_BUFFER;
	endsequence
	sequence data_rd;
		rd_i && addr_i == `SP_OFS_RX_DATA;
	endsequence
	// Two cycles driving, so a one-cycle skew between registers is tolerated
	sequence driving;
		!rx_pin_oe_n_o [*2];
	endsequence

	AST_RESET_STATE: assert property ($fell(srst_i) |-> tx_pin_o && rx_pin_oe_n_o
		&& tx_empty_flag_o && !rx_ready_flag_o && !rx_enable_o)
		else $error("outputs not at reset state");
	AST_WRITE_CLEARS_EMPTY: assert property (buf_wr |=> !tx_empty_flag_o)
		else $error("buffer write left empty flag set");
	AST_EMPTY_FALLS_ON_WRITE: assert property ($fell(tx_empty_flag_o) |->
		$past(wr_i) && $past(addr_i) == `SP_OFS_TX_BUFFER)
		else $error("empty flag cleared without buffer write");
	AST_FLAG_FALLS_ON_READ: assert property ($fell(rx_ready_flag_o) |->
		$past(rd_i) && $past(addr_i) == `SP_OFS_RX_DATA)
		else $error("receive flag cleared without data read");
	AST_DUMMY_DATA: assert property (data_rd |=> rdata_o == `SP_DUMMY_RX_DATA)
		else $error("receive data not dummy");
	AST_RX_INHIBIT: assert property (driving |-> !rx_enable_o)
		else $error("receiver enabled while transmitting");
	AST_TX_INHIBIT: assert property (rx_busy_i && rx_pin_oe_n_o |=> rx_pin_oe_n_o)
		else $error("transmit started while receiving");
	AST_WAKE_INACTIVE: assert property ($rose(rx_ready_flag_o) |-> !$past(rx_enable_o))
		else $error("wake flag with receiver active");
	AST_WAKE_ON_FALL: assert property ($rose(rx_ready_flag_o) |->
		low_run_ff inside {[4'h2:4'h8]})
		else $error("wake flag without falling line");
endmodule

bind serial_port_break_wake_sync_tx sp_properties u_props (
	.clock_i        (clock_i),
	.srst_i         (srst_i),
	.addr_i         (addr_i),
	.wdata_i        (wdata_i),
	.wr_i           (wr_i),
	.rd_i           (rd_i),
	.rdata_o        (rdata_o),
	.rx_busy_i      (rx_busy_i),
	.rx_pin_i       (rx_pin_i),
	.rx_pin_o       (rx_pin_o),
	.rx_pin_oe_n_o  (rx_pin_oe_n_o),
	.tx_pin_o       (tx_pin_o),
	.rx_enable_o    (rx_enable_o),
	.rx_ready_flag_o(rx_ready_flag_o),
	.tx_empty_flag_o(tx_empty_flag_o)
);

/* testbench/line_partner.sv */
// Far-side model: line node and clocked slave
`timescale 1ns/1ps

module line_partner (
	input  wire logic       clock_i,    // Clock
	input  wire logic       break_i,    // Hold line low
	input  wire logic       idle_lvl_i, // Clock idle level
	input  wire logic       clr_i,      // Clear capture
	input  wire logic       sck_i,      // Shift clock
	input  wire logic       dat_i,      // Data drive
	input  wire logic       oe_n_i,     // Drive enable
	output logic            line_o,     // Line level
	output logic      [7:0] word_o,     // Captured bits
	output logic      [3:0] cnt_o       // Bit count
);
	logic lclk = 1'b0;
	logic drv = 1'b1;
	logic sck_q = 1'b1;

	// Own 160 ns clock, offset so it never meets a system edge
	initial begin
		#3;
		forever #80 lclk = ~lclk;
	end

	// Low then high gives the two transitions of a break
	always @(posedge lclk) drv <= ~break_i;

	// Device drive wins over the pulled-up line
	assign line_o = oe_n_i ? drv : dat_i;

	// Take data as the clock leaves idle, shifted in at the top so the first bit ends in bit 0
	always @(posedge clock_i) begin
		sck_q <= sck_i;
		if (clr_i) begin
			cnt_o <= 4'h0;
		end else if (sck_q == idle_lvl_i && sck_i != idle_lvl_i) begin
			word_o <= {dat_i, word_o[7:1]};
			cnt_o <= cnt_o + 4'h1;
		end
	end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the serial port core
`timescale 1ns/1ps

module testbench;
	logic        clock_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [2:0]  addr_i = 3'h0;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        rx_busy_i = 1'b0;
	logic        brk = 1'b0;
	logic        pol = 1'b1;
	logic        clr = 1'b1;
	logic [7:0]  rdata_o;
	logic [7:0]  word;
	logic [3:0]  cnt;
	logic        rx_pin_i;
	logic        rx_pin_o;
	logic        rx_pin_oe_n_o;
	logic        tx_pin_o;
	logic        rx_enable_o;
	logic        rx_ready_flag_o;
	logic        tx_empty_flag_o;
	logic [15:0] f;
	int          fails = 0;
	int          n_tests = 0;

	always #10 clock_i = ~clock_i;

	serial_port_break_wake_sync_tx dut (
		.clock_i        (clock_i),
		.srst_i         (srst_i),
		.addr_i         (addr_i),
		.wdata_i        (wdata_i),
		.wr_i           (wr_i),
		.rd_i           (rd_i),
		.rdata_o        (rdata_o),
		.rx_busy_i      (rx_busy_i),
		.rx_pin_i       (rx_pin_i),
		.rx_pin_o       (rx_pin_o),
		.rx_pin_oe_n_o  (rx_pin_oe_n_o),
		.tx_pin_o       (tx_pin_o),
		.rx_enable_o    (rx_enable_o),
		.rx_ready_flag_o(rx_ready_flag_o),
		.tx_empty_flag_o(tx_empty_flag_o)
	);

	line_partner peer (.clock_i(clock_i), .break_i(brk), .idle_lvl_i(pol), .clr_i(clr),
		.sck_i(tx_pin_o), .dat_i(rx_pin_o), .oe_n_i(rx_pin_oe_n_o), .line_o(rx_pin_i),
		.word_o(word), .cnt_o(cnt));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(nm, {8'h00, e}, {8'h00, rdata_o});
	endtask

	// Frame bits, first into bit 0, two clocks per bit
	task automatic cap(input int n);
		int i;
		f = 16'h0000;
		i = 0;
		while (tx_pin_o !== 1'b0 && i < 60) begin
			@(negedge clock_i);
			i++;
		end
		for (i = 0; i < n; i++) begin
			f[i] = tx_pin_o;
			repeat (2) @(negedge clock_i);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (4) @(posedge clock_i);
		srst_i <= 1'b0;
		rd(3'h3, 8'h02, "txsta reset");
		wr(3'h7, 8'h00);
		wr(3'h3, 8'h00);
		rd(3'h7, 8'h02, "flags");
		rd(3'h3, 8'h02, "shift empty");
		// Async frame, divisor 1
		wr(3'h0, 8'h80);
		wr(3'h6, 8'h01);
		wr(3'h3, 8'h20);
		wr(3'h2, 8'hA5);
		cap(10);
		chk("frame", 16'h034A, f);
		// Break, then preloaded sync byte
		wr(3'h3, 8'h28);
		fork
			cap(14);
			begin
				wr(3'h2, 8'hFF);
				rd(3'h3, 8'h28, "break busy");
				wr(3'h2, 8'h55);
				@(negedge clock_i);
				chk("full", 16'h0000, {15'h0, tx_empty_flag_o});
			end
		join
		chk("break", 16'h2000, f);
		cap(10);
		chk("sync", 16'h02AA, f);
		repeat (4) @(posedge clock_i);
		rd(3'h3, 8'h22, "break cleared");
		rd(3'h7, 8'h02, "empty");
		// Nine-bit async frame: zeros, ninth bit high, stop
		wr(3'h3, 8'h61);
		wr(3'h2, 8'h00);
		cap(11);
		chk("nine async", 16'h0600, f);
		// Divider bytes read back, low byte then set to 1 again; high byte ignored unless wide
		wr(3'h5, 8'h01);
		wr(3'h6, 8'h0C);
		rd(3'h6, 8'h0C, "slow divider");
		rd(3'h5, 8'h01, "divider high");
		wr(3'h6, 8'h01);
		// Wake on line activity
		rd(3'h4, 8'h40, "rx idle");
		chk("rx on", 16'h0001, {15'h0, rx_enable_o});
		wr(3'h4, 8'h02);
		repeat (3) @(negedge clock_i);
		chk("rx off", 16'h0000, {15'h0, rx_enable_o});
		brk <= 1'b1;
		repeat (30) @(negedge clock_i);
		chk("wake flag", 16'h0001, {15'h0, rx_ready_flag_o});
		rd(3'h4, 8'h42, "wake held");
		brk <= 1'b0;
		repeat (30) @(negedge clock_i);
		rd(3'h4, 8'h40, "wake cleared");
		rd(3'h1, 8'h00, "dummy");
		chk("flag read", 16'h0000, {15'h0, rx_ready_flag_o});
		// Clocked master, idle high then low
		wr(3'h4, 8'h10);
		wr(3'h3, 8'hB0);
		repeat (2) @(negedge clock_i);
		chk("idle high", 16'h0001, {15'h0, tx_pin_o});
		clr <= 1'b0;
		wr(3'h2, 8'h3C);
		repeat (4) @(negedge clock_i);
		chk("drive", 16'h0000, {14'h0, rx_pin_oe_n_o, rx_enable_o});
		repeat (56) @(negedge clock_i);
		chk("word", 16'h083C, {4'h0, cnt, word});
		pol <= 1'b0;
		clr <= 1'b1;
		wr(3'h4, 8'h00);
		repeat (2) @(negedge clock_i);
		clr <= 1'b0;
		chk("idle low", 16'h0001, {14'h0, tx_pin_o, rx_pin_oe_n_o});
		@(posedge clock_i);
		rx_busy_i <= 1'b1;
		rd(3'h4, 8'h00, "rx busy");
		wr(3'h2, 8'h81);
		repeat (40) @(negedge clock_i);
		chk("held", 16'h0000, {12'h0, cnt});
		rd(3'h3, 8'hB2, "not loaded");
		@(posedge clock_i);
		rx_busy_i <= 1'b0;
		repeat (60) @(negedge clock_i);
		chk("word 2", 16'h0881, {4'h0, cnt, word});
		// Nine-bit clocked word under the wide divider select
		clr <= 1'b1;
		wr(3'h5, 8'h00);
		wr(3'h4, 8'h08);
		rd(3'h4, 8'h48, "wide select");
		wr(3'h3, 8'hF1);
		clr <= 1'b0;
		wr(3'h2, 8'h5A);
		repeat (60) @(negedge clock_i);
		chk("nine bits", 16'h09AD, {4'h0, cnt, word});
		stop_test;
	end

	// Whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock_i);
		fails++;
		stop_test;
	end
endmodule
